/* File: rtl/ccix_link1_gateway.sv */
// Link 1 control and status bank, link handshake and credit issue.
// Assumes all user-side inputs come from logic on core_clk_i.
//
// Notes on behaviour
// R1: 64-bit control at 0x1C10, secure access only
// R2: Bit 16 enables SMP, reset by build
// R3: Bit 15 sends expanded agent ID
// R4: Bit 14 uses special copy-back credits in SMP
// R5: Bits 13:12 hold override code, reset zero
// R6: Bit 11 overrides exclusive error, non-SMP only
// R7: Software uses exclusive workarounds only non-SMP
// R8: Bit 10 downgrades exclusive stores, non-SMP
// R9: Bit 9 downgrades exclusive loads, non-SMP
// R10: Bit 8 blocks processor events in SMP
// R11: Bits 7:4 snoop share; 0 equal, F none
// R12: Codes 1-4 give quarter to all credits
// R13: Bit 3 drives domain request, reset zero
// R14: Software writes link-up after polling both agents
// R15: Software clears link-up when both agents down
// R16: Link-up clear ignores all remote activity
// R17: Software sets link-up when both agents up
// R18: Link-up set starts issuing local credits
// R19: Software writes bit 1 to request link state
// R20: Bit 0 enables the link, reset zero
// R21: Down set after credits back, cleared on up
// R22: Ack set when ready, cleared on down
// R23: Reserved bits read zero, writes ignored
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
module ccix_link1_gateway #(
  parameter int   LOCAL_CREDITS       = 8,
  parameter int   TOTAL_SNOOP_CREDITS = 32,
  parameter int   LINK_COUNT          = 2,
  parameter int   SNOOP_W             = 8,
  parameter logic SMP_RESET           = 1'b0
) (
  // Clock and reset
  input  wire logic                      core_clk_i,
  input  wire logic                      rst_i,
  // Register access
  ccix_reg_if.device                     bus,
  // Control outputs
  output logic                           symmetric_mode_o,
  output logic                           response_expanded_id_o,
  output logic                           special_writeback_credit_o,
  output logic                           maintenance_domain_request_o,
  output logic                           link_enable_o,
  output logic                           link_up_o,
  output logic [SNOOP_W-1:0]             snoop_credit_count_o,
  // Handshake state
  output logic                           link_ack_o,
  output logic                           link_down_o,
  input  wire logic                      maintenance_domain_ack_i,
  input  wire logic                      writeback_outstanding_i,
  // Credits
  input  wire logic                      credit_return_i,
  output logic                           credit_grant_o,
  input  wire logic                      remote_credit_i,
  output logic                           remote_credit_take_o,
  // Requests and responses
  input  wire logic                      req_valid_i,
  input  wire ccix_link_pkg::req_kind_t  req_kind_i,
  output logic                           req_valid_o,
  output ccix_link_pkg::req_kind_t       req_kind_o,
  input  wire logic                      rsp_valid_i,
  input  wire logic                      rsp_excl_i,
  input  wire logic [1:0]                rsp_err_i,
  output logic                           rsp_valid_o,
  output logic [1:0]                     rsp_err_o,
  // Processor events
  input  wire logic                      cpu_event_i,
  output logic                           cpu_event_o
);

  localparam int CNT_W = $clog2(LOCAL_CREDITS + 1);

  generate
    if (LOCAL_CREDITS < 1 || LINK_COUNT < 1 ||
        TOTAL_SNOOP_CREDITS >= (1 << SNOOP_W)) begin : g_bad_cfg
      $error("unsupported parameter values");
    end
  endgenerate

  logic [ccix_link_pkg::CTL_W-1:0] ctl_r;
  logic                            ack_r;
  logic                            err_r;
  logic [63:0]                     rdata_r;
  logic                            link_ack_r;
  logic                            link_down_r;
  logic [CNT_W-1:0]                out_cnt_r;
  logic [CNT_W-1:0]                out_cnt_nxt;
  logic                            grant;
  logic                            hit_ctl;
  logic                            hit_status;
  logic                            smp;
  logic                            up;
  logic                            en;

  function automatic logic [SNOOP_W-1:0] snoop_share(input logic [3:0] code);
    int n;
    n = 0;
    case (code)
      ccix_link_pkg::SNP_EQUAL:
        n = TOTAL_SNOOP_CREDITS / LINK_COUNT;
      ccix_link_pkg::SNP_QUARTER:
        n = TOTAL_SNOOP_CREDITS >> ccix_link_pkg::QUARTER_SHIFT;
      ccix_link_pkg::SNP_HALF:
        n = TOTAL_SNOOP_CREDITS >> ccix_link_pkg::HALF_SHIFT;
      ccix_link_pkg::SNP_THREE_Q:
        n = TOTAL_SNOOP_CREDITS -
            (TOTAL_SNOOP_CREDITS >> ccix_link_pkg::QUARTER_SHIFT);
      ccix_link_pkg::SNP_FULL:
        n = TOTAL_SNOOP_CREDITS;
      default:
        n = 0;
    endcase
    return SNOOP_W'(n);
  endfunction

  function automatic ccix_link_pkg::req_kind_t downgrade(
    input ccix_link_pkg::req_kind_t kind,
    input logic                     smp_on,
    input logic                     ld_dg,
    input logic                     st_dg
  );
    ccix_link_pkg::req_kind_t k;
    k = kind;
    if (!smp_on && ld_dg && kind == ccix_link_pkg::REQ_EXCL_LOAD) begin
      k = ccix_link_pkg::REQ_LOAD;
    end
    if (!smp_on && st_dg && kind == ccix_link_pkg::REQ_EXCL_STORE) begin
      k = ccix_link_pkg::REQ_STORE;
    end
    return k;
  endfunction

  assign hit_ctl    = bus.addr == ccix_link_pkg::CTL_OFFSET;
  assign hit_status = bus.addr == ccix_link_pkg::STATUS_OFFSET;
  assign smp        = ctl_r[ccix_link_pkg::SMP_BIT];
  assign up         = ctl_r[ccix_link_pkg::LINK_UP_BIT];
  assign en         = ctl_r[ccix_link_pkg::LINK_EN_BIT];

  // Control register write
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctl_r <= {SMP_RESET, ccix_link_pkg::CTL_LOW_RESET}; // [R2] [R5] [R13]
    end else if (bus.req && bus.write && bus.secure && hit_ctl) begin
      ctl_r <= bus.wdata[ccix_link_pkg::CTL_W-1:0]; // [R1] [R23]
    end
  end

  // Read and answer, one cycle after the request
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_r   <= 1'b0;
      err_r   <= 1'b0;
      rdata_r <= 64'h0;
    end else begin
      ack_r   <= bus.req;
      err_r   <= bus.req && !(bus.secure && (hit_ctl || hit_status)); // [R1]
      rdata_r <= 64'h0;
      if (bus.req && !bus.write && bus.secure && hit_ctl) begin
        rdata_r <= 64'(ctl_r); // [R23]
      end else if (bus.req && !bus.write && bus.secure && hit_status) begin
        rdata_r <= 64'({writeback_outstanding_i, maintenance_domain_ack_i,
                        link_down_r, link_ack_r});
      end
    end
  end

  assign bus.ack   = ack_r;
  assign bus.err   = err_r;
  assign bus.rdata = rdata_r;

  // Link down and acknowledge
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      link_down_r <= ccix_link_pkg::DOWN_RESET;
      link_ack_r  <= ccix_link_pkg::ACK_RESET;
    end else if (ctl_r[ccix_link_pkg::LINK_REQ_BIT]) begin
      link_down_r <= 1'b0; // [R21]
      if (!link_down_r && en) begin
        link_ack_r <= 1'b1; // [R22]
      end
    end else begin
      link_ack_r <= 1'b0; // [R22]
      if (out_cnt_r == '0) begin
        link_down_r <= 1'b1; // [R21]
      end
    end
  end

  // Local credits go out only while up and acknowledged
  assign grant = up && link_ack_r && en &&
                 out_cnt_r < CNT_W'(LOCAL_CREDITS); // [R18]

  always_comb begin
    out_cnt_nxt = out_cnt_r;
    if (grant && !(credit_return_i && out_cnt_r != '0)) begin
      out_cnt_nxt = out_cnt_r + CNT_W'(1);
    end else if (!grant && credit_return_i && out_cnt_r != '0) begin
      out_cnt_nxt = out_cnt_r - CNT_W'(1);
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_cnt_r      <= '0;
      credit_grant_o <= 1'b0;
    end else begin
      out_cnt_r      <= out_cnt_nxt;
      credit_grant_o <= grant; // [R18]
    end
  end

  // Remote activity taken only while link is up
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      remote_credit_take_o <= 1'b0;
    end else begin
      remote_credit_take_o <= remote_credit_i && up && en; // [R16] [R21]
    end
  end

  // Request and response shaping
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      req_valid_o <= 1'b0;
      req_kind_o  <= ccix_link_pkg::REQ_LOAD;
      rsp_valid_o <= 1'b0;
      rsp_err_o   <= 2'h0;
      cpu_event_o <= 1'b0;
    end else begin
      req_valid_o <= req_valid_i;
      req_kind_o  <= downgrade(req_kind_i, smp,
                               ctl_r[ccix_link_pkg::LOAD_DG_BIT],
                               ctl_r[ccix_link_pkg::STORE_DG_BIT]); // [R8] [R9]
      rsp_valid_o <= rsp_valid_i;
      if (rsp_excl_i && !smp && ctl_r[ccix_link_pkg::ERR_OVRD_BIT]) begin
        rsp_err_o <= ctl_r[ccix_link_pkg::ERR_CODE_LSB +:
                           ccix_link_pkg::ERR_CODE_W]; // [R5] [R6]
      end else begin
        rsp_err_o <= rsp_err_i;
      end
      cpu_event_o <= cpu_event_i &&
                     !(smp && ctl_r[ccix_link_pkg::EVT_BLK_BIT]); // [R10]
    end
  end

  // Static controls
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      special_writeback_credit_o <= 1'b0;
      snoop_credit_count_o       <= '0;
    end else begin
      special_writeback_credit_o <= smp &&
                                    ctl_r[ccix_link_pkg::SPCL_CRD_BIT]; // [R4]
      snoop_credit_count_o <= snoop_share(
        ctl_r[ccix_link_pkg::SNP_LSB +: ccix_link_pkg::SNP_W]); // [R11] [R12]
    end
  end

  assign symmetric_mode_o             = smp; // [R2]
  assign response_expanded_id_o       = ctl_r[ccix_link_pkg::EXP_ID_BIT]; // [R3]
  assign maintenance_domain_request_o = ctl_r[ccix_link_pkg::DOM_REQ_BIT]; // [R13]
  assign link_enable_o                = en; // [R20]
  assign link_up_o                    = up;
  assign link_ack_o                   = link_ack_r;
  assign link_down_o                  = link_down_r;

endmodule

/* File: rtl/ccix_link_pkg.sv */
// Constants shared by the link 1 bank and its controller.
// Assumes it compiles before all other files.
package ccix_link_pkg;

  // Device register map
  localparam logic [15:0] CTL_OFFSET    = 16'h1c10;
  localparam logic [15:0] STATUS_OFFSET = 16'h1c18;
  localparam int          CTL_W         = 17;
  localparam int          STATUS_W      = 4;

  // Control field positions
  localparam int SMP_BIT       = 16;
  localparam int EXP_ID_BIT    = 15;
  localparam int SPCL_CRD_BIT  = 14;
  localparam int ERR_CODE_LSB  = 12;
  localparam int ERR_CODE_W    = 2;
  localparam int ERR_OVRD_BIT  = 11;
  localparam int STORE_DG_BIT  = 10;
  localparam int LOAD_DG_BIT   = 9;
  localparam int EVT_BLK_BIT   = 8;
  localparam int SNP_LSB       = 4;
  localparam int SNP_W         = 4;
  localparam int DOM_REQ_BIT   = 3;
  localparam int LINK_UP_BIT   = 2;
  localparam int LINK_REQ_BIT  = 1;
  localparam int LINK_EN_BIT   = 0;

  // Status field positions
  localparam int ST_ACK_BIT     = 0;
  localparam int ST_DOWN_BIT    = 1;
  localparam int ST_DOM_ACK_BIT = 2;
  localparam int ST_CBKWR_BIT   = 3;

  // Reset values
  localparam logic [15:0] CTL_LOW_RESET = 16'h0000;
  localparam logic        DOWN_RESET    = 1'b1;
  localparam logic        ACK_RESET     = 1'b0;

  // Snoop share codes
  localparam logic [3:0] SNP_EQUAL   = 4'h0;
  localparam logic [3:0] SNP_QUARTER = 4'h1;
  localparam logic [3:0] SNP_HALF    = 4'h2;
  localparam logic [3:0] SNP_THREE_Q = 4'h3;
  localparam logic [3:0] SNP_FULL    = 4'h4;
  localparam logic [3:0] SNP_NONE    = 4'hf;
  localparam int         QUARTER_SHIFT = 2;
  localparam int         HALF_SHIFT    = 1;

  typedef enum logic [1:0] {
    REQ_LOAD       = 2'h0,
    REQ_STORE      = 2'h1,
    REQ_EXCL_LOAD  = 2'h2,
    REQ_EXCL_STORE = 2'h3
  } req_kind_t;

  // Controller APB map
  localparam logic [7:0] APB_IMAGE    = 8'h00;
  localparam logic [7:0] APB_ACCESS   = 8'h04;
  localparam logic [7:0] APB_WDATA_LO = 8'h08;
  localparam logic [7:0] APB_WDATA_HI = 8'h0c;
  localparam logic [7:0] APB_RDATA_LO = 8'h10;
  localparam logic [7:0] APB_RDATA_HI = 8'h14;
  localparam logic [7:0] APB_STATUS   = 8'h18;
  localparam logic [7:0] APB_SEQUENCE = 8'h1c;
  localparam int         ACCESS_WRITE_BIT = 16;

  typedef enum logic [2:0] {
    C_IDLE = 3'b000,
    C_REQ  = 3'b001,
    C_POLL = 3'b011,
    C_FLAG = 3'b010,
    C_RAW  = 3'b100
  } ctrl_state_t;

endpackage

/* File: rtl/ccix_reg_if.sv */
// Bank access carrier between controller and gateway.
// Assumes one clock; the controller requests.
`timescale 1ns/1ps
interface ccix_reg_if (
  input wire logic core_clk_i,
  input wire logic rst_i
);
  logic        req;
  logic        write;
  logic        secure;
  logic [15:0] addr;
  logic [63:0] wdata;
  logic        ack;
  logic        err;
  logic [63:0] rdata;

  modport device (
    input  req, write, secure, addr, wdata,
    output ack, err, rdata
  );
  modport ctrl (
    output req, write, secure, addr, wdata,
    input  ack, err, rdata
  );
endinterface

/* File: rtl/ccix_link_controller.sv */
// Controller: APB registers, raw bank access, link sequencing.
// Assumes remote agent status pins are asynchronous.
`timescale 1ns/1ps
module ccix_link_controller #(
  parameter logic SECURE_ACCESS = 1'b1
) (
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Remote agent status
  input  wire logic        remote_ack_i,
  input  wire logic        remote_down_i,
  // Bank access
  ccix_reg_if.ctrl         bus
);

  ccix_link_pkg::ctrl_state_t state_r;
  logic [ccix_link_pkg::CTL_W-1:0] image_r;
  logic [15:0]             raw_addr_r;
  logic                    raw_wr_r;
  logic [63:0]             wdata_r;
  logic [63:0]             rdata_r;
  logic                    err_r;
  logic                    seq_up_r;
  logic                    wait_r;
  logic                    req_r;
  logic                    bwrite_r;
  logic [15:0]             baddr_r;
  logic [63:0]             bwdata_r;
  logic [1:0]              ack_sync_r;
  logic [1:0]              down_sync_r;
  logic                    acc;
  logic                    idle;
  logic                    done;
  logic                    r_ack;
  logic                    r_down;

  // Exclusive workarounds dropped in SMP
  function automatic logic [63:0] ctl_word(
    input logic [ccix_link_pkg::CTL_W-1:0] img,
    input logic                            link_up,
    input logic                            link_req
  );
    logic [63:0] w;
    w = 64'(img);
    if (img[ccix_link_pkg::SMP_BIT]) begin
      w[ccix_link_pkg::ERR_OVRD_BIT] = 1'b0; // [R7]
      w[ccix_link_pkg::STORE_DG_BIT] = 1'b0;
      w[ccix_link_pkg::LOAD_DG_BIT]  = 1'b0;
    end
    w[ccix_link_pkg::LINK_EN_BIT]  = 1'b1;
    w[ccix_link_pkg::LINK_UP_BIT]  = link_up;
    w[ccix_link_pkg::LINK_REQ_BIT] = link_req; // [R19]
    return w;
  endfunction

  assign acc    = psel_i && penable_i && pready_o;
  assign idle   = state_r == ccix_link_pkg::C_IDLE;
  assign r_ack  = ack_sync_r[1];
  assign r_down = down_sync_r[1];
  assign done   = seq_up_r ?
    (bus.rdata[ccix_link_pkg::ST_ACK_BIT] &&
     !bus.rdata[ccix_link_pkg::ST_DOWN_BIT] && r_ack && !r_down) : // [R17]
    (!bus.rdata[ccix_link_pkg::ST_ACK_BIT] &&
     bus.rdata[ccix_link_pkg::ST_DOWN_BIT] && !r_ack && r_down); // [R15]

  // Remote status synchronisers
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_sync_r  <= 2'h0;
      down_sync_r <= 2'h3;
    end else begin
      ack_sync_r  <= {ack_sync_r[0], remote_ack_i};
      down_sync_r <= {down_sync_r[0], remote_down_i};
    end
  end

  // APB answer, no wait states
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0;
    end else begin
      pready_o  <= psel_i && !penable_i;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0;
      if (psel_i && !penable_i) begin
        case (paddr_i)
          ccix_link_pkg::APB_IMAGE:    prdata_o <= 32'(image_r);
          ccix_link_pkg::APB_ACCESS:
            prdata_o <= {15'h0, raw_wr_r, raw_addr_r};
          ccix_link_pkg::APB_WDATA_LO: prdata_o <= wdata_r[31:0];
          ccix_link_pkg::APB_WDATA_HI: prdata_o <= wdata_r[63:32];
          ccix_link_pkg::APB_RDATA_LO: prdata_o <= rdata_r[31:0];
          ccix_link_pkg::APB_RDATA_HI: prdata_o <= rdata_r[63:32];
          ccix_link_pkg::APB_STATUS:
            prdata_o <= {25'h0, r_down, r_ack, state_r, err_r, !idle};
          ccix_link_pkg::APB_SEQUENCE: prdata_o <= {31'h0, seq_up_r};
          default:                     pslverr_o <= 1'b1;
        endcase
      end
    end
  end

  // Software-written registers
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      image_r <= '0;
      wdata_r <= 64'h0;
    end else if (acc && pwrite_i) begin
      if (paddr_i == ccix_link_pkg::APB_IMAGE) begin
        image_r <= pwdata_i[ccix_link_pkg::CTL_W-1:0];
      end
      if (paddr_i == ccix_link_pkg::APB_WDATA_LO) begin
        wdata_r[31:0] <= pwdata_i;
      end
      if (paddr_i == ccix_link_pkg::APB_WDATA_HI) begin
        wdata_r[63:32] <= pwdata_i;
      end
    end
  end

  // Sequencer and bank access engine
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r    <= ccix_link_pkg::C_IDLE;
      raw_addr_r <= 16'h0;
      raw_wr_r   <= 1'b0;
      seq_up_r   <= 1'b0;
      wait_r     <= 1'b0;
      req_r      <= 1'b0;
      bwrite_r   <= 1'b0;
      baddr_r    <= 16'h0;
      bwdata_r   <= 64'h0;
      rdata_r    <= 64'h0;
      err_r      <= 1'b0;
    end else begin
      req_r <= 1'b0;
      case (state_r)
        ccix_link_pkg::C_IDLE: begin
          if (acc && pwrite_i && paddr_i == ccix_link_pkg::APB_ACCESS) begin
            raw_addr_r <= pwdata_i[15:0];
            raw_wr_r   <= pwdata_i[ccix_link_pkg::ACCESS_WRITE_BIT];
            state_r    <= ccix_link_pkg::C_RAW;
          end else if (acc && pwrite_i &&
                       paddr_i == ccix_link_pkg::APB_SEQUENCE) begin
            seq_up_r <= pwdata_i[0];
            state_r  <= ccix_link_pkg::C_REQ;
          end
        end
        ccix_link_pkg::C_RAW: begin
          if (!wait_r) begin
            req_r    <= 1'b1;
            wait_r   <= 1'b1;
            bwrite_r <= raw_wr_r;
            baddr_r  <= raw_addr_r;
            bwdata_r <= wdata_r;
          end else if (bus.ack) begin
            wait_r  <= 1'b0;
            rdata_r <= bus.rdata;
            err_r   <= bus.err;
            state_r <= ccix_link_pkg::C_IDLE;
          end
        end
        ccix_link_pkg::C_REQ: begin
          if (!wait_r) begin
            req_r    <= 1'b1;
            wait_r   <= 1'b1;
            bwrite_r <= 1'b1;
            baddr_r  <= ccix_link_pkg::CTL_OFFSET;
            bwdata_r <= ctl_word(image_r, !seq_up_r, seq_up_r); // [R19]
          end else if (bus.ack) begin
            wait_r  <= 1'b0;
            err_r   <= bus.err;
            state_r <= bus.err ? ccix_link_pkg::C_IDLE : ccix_link_pkg::C_POLL;
          end
        end
        ccix_link_pkg::C_POLL: begin
          if (!wait_r) begin
            req_r    <= 1'b1;
            wait_r   <= 1'b1;
            bwrite_r <= 1'b0;
            baddr_r  <= ccix_link_pkg::STATUS_OFFSET;
          end else if (bus.ack) begin
            wait_r  <= 1'b0;
            rdata_r <= bus.rdata;
            if (done) begin
              state_r <= ccix_link_pkg::C_FLAG; // [R14]
            end
          end
        end
        ccix_link_pkg::C_FLAG: begin
          if (!wait_r) begin
            req_r    <= 1'b1;
            wait_r   <= 1'b1;
            bwrite_r <= 1'b1;
            baddr_r  <= ccix_link_pkg::CTL_OFFSET;
            bwdata_r <= ctl_word(image_r, seq_up_r, seq_up_r); // [R15] [R17]
          end else if (bus.ack) begin
            wait_r  <= 1'b0;
            err_r   <= bus.err;
            state_r <= ccix_link_pkg::C_IDLE;
          end
        end
        default: begin
          wait_r  <= 1'b0;
          state_r <= ccix_link_pkg::C_IDLE;
        end
      endcase
    end
  end

  assign bus.req    = req_r;
  assign bus.write  = bwrite_r;
  assign bus.secure = SECURE_ACCESS;
  assign bus.addr   = baddr_r;
  assign bus.wdata  = bwdata_r;

endmodule

/* File: bench/ccix_link1_asserts.sv */
// Checker on the bank access carrier.
// Assumes one clock; instantiated beside the carrier.
`timescale 1ns/1ps
module ccix_link1_asserts (
  // Carrier signals
  input wire logic        core_clk_i,
  input wire logic        rst_i,
  input wire logic        req,
  input wire logic        write,
  input wire logic        secure,
  input wire logic [15:0] addr,
  input wire logic [63:0] wdata,
  input wire logic        ack,
  input wire logic        err,
  input wire logic [63:0] rdata
);
  logic        ctl_hit;
  logic        st_hit;
  logic [16:0] shadow_r;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  assign ctl_hit = addr == ccix_link_pkg::CTL_OFFSET;
  assign st_hit  = addr == ccix_link_pkg::STATUS_OFFSET;
  // Last control word written
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i)
      shadow_r <= 17'h0;
    else if (req && write && secure && ctl_hit)
      shadow_r <= wdata[16:0];
  end
  sequence ctl_read;
    ack && !write && ctl_hit && !err;
  endsequence
  sequence bad_req;
    req && !ctl_hit && !st_hit;
  endsequence
  ack_follow_a: assert property (req |=> ack)
    else $error("bank answer missing");
  ack_cause_a: assert property (ack |-> $past(req))
    else $error("bank answer without request");
  bad_addr_a: assert property (bad_req |=> err && rdata == 64'h0)
    else $error("unmapped access not refused");
  good_addr_a: assert property (req && secure && (ctl_hit || st_hit) |=> !err)
    else $error("mapped access refused");
  ctl_resv_a: assert property (ctl_read |-> rdata[63:17] == 47'h0)
    else $error("control reserved bits not zero");
  stat_resv_a: assert property (ack && !write && st_hit |-> rdata[63:4] == 60'h0)
    else $error("status reserved bits not zero");
  write_quiet_a: assert property (ack && write |-> rdata == 64'h0)
    else $error("read data on write answer");
  ctl_back_a: assert property (ctl_read |-> rdata[16:0] == shadow_r)
    else $error("control readback differs");
endmodule

/* File: bench/ccix_link1_protocol_control_bench.sv */
// Bench: link 1 bank driven through the controller's APB.
// Assumes the package and design files compile first.
`timescale 1ns/1ps
module ccix_link1_protocol_control_bench;
  localparam int TOT = 32;
  localparam int NL  = 2;
  logic core_clk_i = 1'h0, rst_i = 1'h1;
  logic psel_i = 1'h0, penable_i = 1'h0, pwrite_i = 1'h0;
  logic [7:0]  paddr_i = 8'h0;
  logic [31:0] pwdata_i = 32'h0, prdata_o, st, r;
  logic [3:0]  hv = 4'h0;
  logic [1:0]  vo;
  logic rack = 1'h0, rdown = 1'h1, cret = 1'h0, pready_o;
  logic smp, expid, spwb, dom, up, grant, take, evt_o;
  logic [1:0]  rsp_err;
  logic [7:0]  snoop;
  logic [63:0] q;
  logic [3:0]  codes [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'hf};
  ccix_link_pkg::req_kind_t kind = ccix_link_pkg::REQ_LOAD, kind_o;
  int miscompares = 0, check_count = 0, grants = 0, takes = 0;
  always #5 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    if (grant === 1'h1) grants++;
    if (take === 1'h1) takes++;
  end
  ccix_reg_if ccix_reg_if_i (.core_clk_i(core_clk_i), .rst_i(rst_i));
  ccix_link_controller ccix_link_controller_i (.core_clk_i(core_clk_i),
    .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(),
    .remote_ack_i(rack), .remote_down_i(rdown), .bus(ccix_reg_if_i));
  ccix_link1_gateway #(.LOCAL_CREDITS(8), .TOTAL_SNOOP_CREDITS(TOT),
    .LINK_COUNT(NL)) ccix_link1_gateway_i (.core_clk_i(core_clk_i),
    .rst_i(rst_i), .bus(ccix_reg_if_i), .symmetric_mode_o(smp),
    .response_expanded_id_o(expid), .special_writeback_credit_o(spwb),
    .maintenance_domain_request_o(dom), .link_enable_o(),
    .link_up_o(up), .snoop_credit_count_o(snoop), .link_ack_o(),
    .link_down_o(), .maintenance_domain_ack_i(1'h1),
    .writeback_outstanding_i(1'h1), .credit_return_i(cret),
    .credit_grant_o(grant), .remote_credit_i(hv[3]),
    .remote_credit_take_o(take), .req_valid_i(hv[0]), .req_kind_i(kind),
    .req_valid_o(vo[0]), .req_kind_o(kind_o), .rsp_valid_i(hv[1]),
    .rsp_excl_i(1'h1), .rsp_err_i(2'h0), .rsp_valid_o(vo[1]),
    .rsp_err_o(rsp_err), .cpu_event_i(hv[2]), .cpu_event_o(evt_o));
  ccix_link1_asserts ccix_link1_asserts_i (.core_clk_i(core_clk_i),
    .rst_i(rst_i), .req(ccix_reg_if_i.req), .write(ccix_reg_if_i.write),
    .secure(ccix_reg_if_i.secure), .addr(ccix_reg_if_i.addr),
    .wdata(ccix_reg_if_i.wdata), .ack(ccix_reg_if_i.ack),
    .err(ccix_reg_if_i.err), .rdata(ccix_reg_if_i.rdata));
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] o);
    int n;
    @(posedge core_clk_i);
    psel_i <= 1'h1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge core_clk_i);
    penable_i <= 1'h1;
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (pready_o !== 1'h1 && n < 50);
    if (n >= 50) begin
      miscompares++;
      test_done();
    end
    o = prdata_o;
    psel_i <= 1'h0;
    penable_i <= 1'h0;
  endtask
  task automatic wbusy();
    int n;
    n = 0;
    do begin
      apb(1'h0, 8'h18, 32'h0, st);
      n++;
    end while (st[0] !== 1'h0 && n < 60);
    if (n >= 60) begin
      miscompares++;
      test_done();
    end
  endtask
  task automatic raw(input logic w, input logic [15:0] a,
                     input logic [63:0] d);
    logic [31:0] lo;
    apb(1'h1, 8'h08, d[31:0], lo);
    apb(1'h1, 8'h0c, d[63:32], lo);
    apb(1'h1, 8'h04, {15'h0, w, a}, lo);
    wbusy();
    apb(1'h0, 8'h10, 32'h0, lo);
    apb(1'h0, 8'h14, 32'h0, r);
    q = {r, lo};
  endtask
  task automatic hit(input logic [1:0] k);
    @(posedge core_clk_i);
    hv <= 4'hf;
    kind <= ccix_link_pkg::req_kind_t'(k);
    @(posedge core_clk_i);
    hv <= 4'h0;
    #1;
  endtask
  initial begin
    repeat (8) @(posedge core_clk_i);
    rst_i <= 1'h0;
    raw(1'h0, 16'h1c18, 64'h0);
    chk(q, 64'he);
    raw(1'h0, 16'h1c10, 64'h0);
    chk(q, 64'h0);
    $display("test reset done");
    raw(1'h1, 16'h1c10, 64'hffff_ffff_ffff_fff8);
    raw(1'h0, 16'h1c10, 64'h0);
    chk(q, 64'h1fff8);
    hit(2'h3);
    q = 64'({vo, smp, expid, spwb, dom, evt_o, kind_o, rsp_err});
    chk(q, 64'h7ec);
    raw(1'h1, 16'h1c20, 64'h0);
    chk(64'(st[1]), 64'h1);
    raw(1'h1, 16'h1c10, 64'h2e00);
    for (int i = 0; i < 2; i++) begin
      hit(2'(i + 2));
      q = 64'({spwb, evt_o, kind_o, rsp_err});
      chk(q, 64'({4'(4 + i), 2'h2}));
    end
    $display("test modes done");
    foreach (codes[i]) begin
      raw(1'h1, 16'h1c10, 64'(codes[i]) << 4);
      q = 64'(codes[i] == 4'hf ? 0 : codes[i] ? TOT * codes[i] / 4 : TOT / NL);
      chk(64'(snoop), q);
    end
    $display("test snoop done");
    chk(64'(takes), 64'h0);
    rack <= 1'h1;
    rdown <= 1'h0;
    apb(1'h1, 8'h1c, 32'h1, r);
    wbusy();
    repeat (20) @(posedge core_clk_i);
    chk(64'({up, 8'(grants)}), 64'h108);
    raw(1'h0, 16'h1c18, 64'h0);
    chk(q, 64'hd);
    hit(2'h0);
    apb(1'h1, 8'h1c, 32'h0, r);
    rack <= 1'h0;
    rdown <= 1'h1;
    cret <= 1'h1;
    wbusy();
    raw(1'h0, 16'h1c18, 64'h0);
    chk(64'({up, 8'(takes), q[3:0]}), 64'h1e);
    $display("test link done");
    test_done();
  end
endmodule
